// ==== inc/mcw_pkg.sv ====
package mcw_pkg;

  localparam int          MC_MSB        = 4;
  localparam logic [4:0]  MC_DATA_MIN   = 5'h10;
  localparam logic [4:0]  MC_UNDEF_A    = 5'h10;
  localparam logic [4:0]  MC_UNDEF_B    = 5'h12;
  localparam logic [4:0]  MC_UNDEF_C    = 5'h13;

  localparam logic [15:0] REC_TAG_OFS   = 16'h0001;
  localparam logic [15:0] REC_DATA_OFS  = 16'h0002;

  localparam int          ST_IWD        = 14;
  localparam int          ST_GAP        = 13;
  localparam int          ST_WCT        = 12;
  localparam int          ST_SYN        = 11;
  localparam int          ST_MESSAGE_ERROR_SUMMARY       = 10;
  localparam int          ST_BUSY       = 9;
  localparam int          ST_ILL        = 8;
  localparam int          ST_BUS        = 5;

  localparam logic [7:0]  REG_CFG       = 8'h00;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h04;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  REG_LAST_STAT = 8'h0C;
  localparam logic [7:0]  REG_COUNT     = 8'h10;

  localparam int          CFG_UNDEFINED_MODE_INVALID_BIT    = 0;
  localparam int          CFG_BUSY      = 1;
  localparam int          CFG_BCAST_SEL = 3;
  localparam logic [15:0] CFG_RST       = 16'h0000;

  localparam int          IRQ_W         = 3;
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_MESSAGE_ERROR_SUMMARY      = 1;
  localparam int          IRQ_ILL       = 2;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

  typedef enum logic [4:0] {
    MCW_IDLE    = 5'b00001,
    MCW_RECV    = 5'b00010,
    MCW_WR_STAT = 5'b00100,
    MCW_WR_TAG  = 5'b01000,
    MCW_WR_DATA = 5'b10000
  } mcw_state_e;

  function automatic logic mcw_undef_rx(input logic [4:0] mc);
    mcw_undef_rx = (mc < MC_DATA_MIN) || (mc == MC_UNDEF_A) ||
                   (mc == MC_UNDEF_B) || (mc == MC_UNDEF_C);
  endfunction : mcw_undef_rx

  function automatic logic mcw_has_data(input logic [4:0] mc);
    mcw_has_data = (mc >= MC_DATA_MIN);
  endfunction : mcw_has_data

endpackage : mcw_pkg

// ==== src/mcw_status_word.sv ====
`timescale 1ns/100ps
module mcw_status_word
  import mcw_pkg::*;
(
  input  wire logic [4:0]  mode_code_field,
  input  wire logic        bus_select_flag,
  input  wire logic        illegal_command_flag,
  input  wire logic        answered_busy_flag,
  input  wire logic        sync_type_error_flag,
  input  wire logic        word_count_error_flag,
  input  wire logic        gap_or_broadcast_flag,
  input  wire logic        invalid_word_flag,
  output logic      [15:0] status_word
);
  logic message_error_summary;

  // summary of bits 11 to 14
  assign message_error_summary = invalid_word_flag | gap_or_broadcast_flag |
                                 word_count_error_flag | sync_type_error_flag;

  always_comb begin
    status_word                  = 16'h0000;
    status_word[ST_IWD]          = invalid_word_flag;
    status_word[ST_GAP]          = gap_or_broadcast_flag;
    status_word[ST_WCT]          = word_count_error_flag;
    status_word[ST_SYN]          = sync_type_error_flag;
    status_word[ST_MESSAGE_ERROR_SUMMARY]         = message_error_summary;
    status_word[ST_BUSY]         = answered_busy_flag;
    status_word[ST_ILL]          = illegal_command_flag;
    status_word[ST_BUS]          = bus_select_flag;
    status_word[MC_MSB:0]        = mode_code_field;
  end

endmodule : mcw_status_word

// ==== src/mcw_record_writer.sv ====
`timescale 1ns/100ps
module mcw_record_writer
  import mcw_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        msg_start,
  input  wire logic [15:0] cmd_word,
  input  wire logic [15:0] desc_ptr,
  input  wire logic        force_busy_bit,
  input  wire logic        illegal_bit,
  input  wire logic        bus_b,
  input  wire logic        broadcast,
  input  wire logic [15:0] time_tag,
  input  wire logic        data_valid,
  input  wire logic [15:0] data_word,
  input  wire logic        manchester_err,
  input  wire logic        parity_err,
  input  wire logic        cmd_sync_err,
  input  wire logic        gap_err,
  input  wire logic        msg_end,
  output logic             respond_in_form,
  output logic             answered_busy,
  output logic             mem_wr,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic             irq
);

  typedef struct packed {
    mcw_state_e        st;
    logic [4:0]        mc;
    logic [15:0]       base;
    logic [15:0]       tag;
    logic              busy;
    logic              ill;
    logic              bus_b;
    logic              bcast;
    logic [1:0]        nwords;
    logic [15:0]       dword;
    logic              iwd;
    logic              gap;
    logic              syn;
    logic              in_form;
    logic              mem_wr;
    logic [15:0]       mem_addr;
    logic [15:0]       mem_wdata;
    logic [15:0]       cfg;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [15:0]       last_stat;
    logic [15:0]       count;
    logic [15:0]       rdata;
    logic              irq;
  } mcw_regs_s;

  localparam mcw_regs_s REGS_RST = '{
    st: MCW_IDLE, mc: 5'h00, base: 16'h0000, tag: 16'h0000, busy: 1'b0,
    ill: 1'b0, bus_b: 1'b0, bcast: 1'b0, nwords: 2'h0, dword: 16'h0000,
    iwd: 1'b0, gap: 1'b0, syn: 1'b0, in_form: 1'b0, mem_wr: 1'b0,
    mem_addr: 16'h0000, mem_wdata: 16'h0000, cfg: CFG_RST,
    irq_stat: 3'h0, irq_mask: IRQ_MASK_RST, last_stat: 16'h0000,
    count: 16'h0000, rdata: 16'h0000, irq: 1'b0
  };

  mcw_regs_s        q_r;
  mcw_regs_s        q_nxt;
  logic [15:0]      stat_word;
  logic             wct;
  logic             gap_sel;
  logic             start_ok;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;

  // missing or extra data word
  assign wct = mcw_has_data(q_r.mc) ? (q_r.nwords != 2'h1)
                                    : (q_r.nwords != 2'h0);
  assign gap_sel = q_r.cfg[CFG_BCAST_SEL] ? q_r.bcast : q_r.gap;
  assign start_ok = msg_start && (q_r.st == MCW_IDLE || q_r.st == MCW_RECV);

  mcw_status_word u_stat (
    .mode_code_field       (q_r.mc),
    .bus_select_flag       (q_r.bus_b),
    .illegal_command_flag  (q_r.ill),
    .answered_busy_flag    (q_r.busy),
    .sync_type_error_flag  (q_r.syn),
    .word_count_error_flag (wct),
    .gap_or_broadcast_flag (gap_sel),
    .invalid_word_flag     (q_r.iwd),
    .status_word           (stat_word)
  );

  always_comb begin
    q_nxt = q_r;
    q_nxt.mem_wr = 1'b0;
    q_nxt.rdata = 16'h0000;
    irq_evt = '0;
    irq_clr = '0;
    if (start_ok) begin
      q_nxt.st = MCW_RECV;
      q_nxt.mc = cmd_word[MC_MSB:0];
      q_nxt.base = desc_ptr;
      q_nxt.tag = time_tag;
      q_nxt.busy = force_busy_bit | q_r.cfg[CFG_BUSY];
      q_nxt.ill = illegal_bit;
      q_nxt.bus_b = bus_b;
      q_nxt.bcast = broadcast;
      q_nxt.nwords = 2'h0;
      q_nxt.iwd = 1'b0;
      q_nxt.gap = 1'b0;
      q_nxt.syn = 1'b0;
      // undefined codes answer only when legal and not forced invalid
      q_nxt.in_form = !illegal_bit &&
        !(mcw_undef_rx(cmd_word[MC_MSB:0]) && q_r.cfg[CFG_UNDEFINED_MODE_INVALID_BIT]);
    end else begin
      case (q_r.st)
        MCW_IDLE: begin
        end
        MCW_RECV: begin
          if (msg_end) begin
            // nothing reaches memory before the message completes
            q_nxt.st = MCW_WR_STAT;
            q_nxt.mem_wr = 1'b1;
            q_nxt.mem_addr = q_r.base;
            q_nxt.mem_wdata = stat_word;
          end else begin
            if (data_valid) begin
              if (q_r.nwords == 2'h0) begin
                q_nxt.dword = data_word;
              end
              if (q_r.nwords != 2'h2) begin
                q_nxt.nwords = q_r.nwords + 2'h1;
              end
              if (manchester_err || parity_err) begin
                q_nxt.iwd = 1'b1;
              end
              if (cmd_sync_err) begin
                q_nxt.syn = 1'b1;
              end
            end
            if (gap_err) begin
              q_nxt.gap = 1'b1;
            end
          end
        end
        MCW_WR_STAT: begin
          q_nxt.st = MCW_WR_TAG;
          q_nxt.mem_wr = 1'b1;
          q_nxt.mem_addr = q_r.base + REC_TAG_OFS;
          q_nxt.mem_wdata = q_r.tag;
        end
        MCW_WR_TAG: begin
          if (mcw_has_data(q_r.mc) && q_r.nwords != 2'h0) begin
            q_nxt.st = MCW_WR_DATA;
            q_nxt.mem_wr = 1'b1;
            q_nxt.mem_addr = q_r.base + REC_DATA_OFS;
            q_nxt.mem_wdata = q_r.dword;
          end else begin
            q_nxt.st = MCW_IDLE;
          end
        end
        MCW_WR_DATA: begin
          q_nxt.st = MCW_IDLE;
        end
        default: begin
          q_nxt.st = MCW_IDLE;
        end
      endcase
    end

    // record events, taken while the status word sits on the memory port
    if (q_r.st == MCW_WR_STAT) begin
      irq_evt[IRQ_DONE] = 1'b1;
      irq_evt[IRQ_MESSAGE_ERROR_SUMMARY] = q_r.mem_wdata[ST_MESSAGE_ERROR_SUMMARY];
      irq_evt[IRQ_ILL] = q_r.mem_wdata[ST_ILL];
      q_nxt.last_stat = q_r.mem_wdata;
      q_nxt.count = q_r.count + 16'h0001;
    end

    if (reg_wr) begin
      if (reg_addr == REG_CFG) begin
        q_nxt.cfg = reg_wdata;
      end else if (reg_addr == REG_IRQ_STAT) begin
        irq_clr = reg_wdata[IRQ_W-1:0];
      end else if (reg_addr == REG_IRQ_MASK) begin
        q_nxt.irq_mask = reg_wdata[IRQ_W-1:0];
      end
    end
    // set wins over clear
    q_nxt.irq_stat = (q_r.irq_stat & ~irq_clr) | irq_evt;
    q_nxt.irq = |(q_nxt.irq_stat & q_nxt.irq_mask);

    if (reg_rd) begin
      if (reg_addr == REG_CFG) begin
        q_nxt.rdata = q_r.cfg;
      end else if (reg_addr == REG_IRQ_STAT) begin
        q_nxt.rdata = {13'h0000, q_r.irq_stat};
      end else if (reg_addr == REG_IRQ_MASK) begin
        q_nxt.rdata = {13'h0000, q_r.irq_mask};
      end else if (reg_addr == REG_LAST_STAT) begin
        q_nxt.rdata = q_r.last_stat;
      end else if (reg_addr == REG_COUNT) begin
        q_nxt.rdata = q_r.count;
      end else begin
        q_nxt.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= REGS_RST;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign respond_in_form = q_r.in_form;
  assign answered_busy = q_r.busy;
  assign mem_wr = q_r.mem_wr;
  assign mem_addr = q_r.mem_addr;
  assign mem_wdata = q_r.mem_wdata;
  assign irq = q_r.irq;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst || !ce);

  logic [15:0] base_h;
  logic [4:0]  mc_h;
  assign base_h = q_r.base;
  assign mc_h = q_r.mc;

  sequence s_end;
    q_r.st == MCW_RECV && msg_end && !msg_start && ce;
  endsequence

  sequence s_head;
    mem_wr && mem_addr == base_h ##1 mem_wr && mem_addr == base_h + REC_TAG_OFS;
  endsequence

  a_record_head: assert property (s_end |=> s_head)
    else $error("status and time tag not written at base and base+1");

  a_data_word: assert property (
    s_end ##0 (mcw_has_data(mc_h) && q_r.nwords != 2'h0)
      |=> ##2 mem_wr && mem_addr == base_h + REC_DATA_OFS)
    else $error("mode data word not written at base+2");

  a_no_data: assert property (
    s_end ##0 !mcw_has_data(mc_h) |=> ##2 !mem_wr && q_r.st == MCW_IDLE)
    else $error("short record wrote a third word");

  a_after_end: assert property (
    q_r.st == MCW_RECV |-> !mem_wr)
    else $error("memory written before message end");

  a_fixed_bits: assert property (
    q_r.st == MCW_WR_STAT |-> !mem_wdata[15] && mem_wdata[7:6] == 2'b00 &&
      mem_wdata[MC_MSB:0] == mc_h && mem_wdata[ST_BUS] == q_r.bus_b)
    else $error("status word fixed fields wrong");

  a_message_error_summary_sum: assert property (
    q_r.st == MCW_WR_STAT |-> mem_wdata[ST_MESSAGE_ERROR_SUMMARY] == |mem_wdata[ST_IWD:ST_SYN])
    else $error("message error summary inconsistent");

  a_time_tag: assert property (
    start_ok |=> q_r.tag == $past(time_tag))
    else $error("time tag not captured at message start");

  a_tag_word: assert property (
    q_r.st == MCW_WR_TAG |-> mem_wdata == q_r.tag)
    else $error("time tag word not the captured value");

  a_undef_low: assert property (
    msg_start && q_r.st == MCW_IDLE && cmd_word[MC_MSB:0] < MC_DATA_MIN &&
      q_r.cfg[CFG_UNDEFINED_MODE_INVALID_BIT] |=> !respond_in_form)
    else $error("undefined low code answered in form");

  a_illegal_cmd: assert property (
    msg_start && q_r.st == MCW_IDLE && illegal_bit
      |=> !respond_in_form ##0 q_r.ill)
    else $error("illegal command not flagged");

  a_extra_word: assert property (
    q_r.st == MCW_RECV && !mcw_has_data(mc_h) && q_r.nwords != 2'h0 && msg_end
      && !msg_start |=> mem_wdata[ST_WCT] && mem_wdata[ST_MESSAGE_ERROR_SUMMARY])
    else $error("word count error not flagged");

endmodule : mcw_record_writer

// ==== testbench/mcw_bc_model.sv ====
`timescale 1ns/100ps
module mcw_bc_model (
  input  wire logic        clk_sys,
  output logic             msg_start,
  output logic      [15:0] cmd_word,
  output logic             data_valid,
  output logic      [15:0] data_word,
  output logic             manchester_err,
  output logic             parity_err,
  output logic             cmd_sync_err,
  output logic             gap_err,
  output logic             msg_end
);

  initial begin
    {msg_start, data_valid, manchester_err, parity_err, cmd_sync_err} = 5'h00;
    {gap_err, msg_end} = 2'h0;
    cmd_word  = 16'h0000;
    data_word = 16'h0000;
  end

  // receive mode command; err = {gap, sync, parity, manchester}
  task automatic send(input logic [4:0] mc, input int nd, input logic [15:0] dw,
                      input logic [3:0] err);
    @(posedge clk_sys);
    msg_start <= 1'b1;
    cmd_word  <= {11'h0C0, mc};
    for (int i = 0; i < nd; i++) begin
      @(posedge clk_sys);
      msg_start      <= 1'b0;
      data_valid     <= 1'b1;
      data_word      <= dw + 16'(i);
      manchester_err <= err[0];
      parity_err     <= err[1];
      cmd_sync_err   <= err[2];
    end
    @(posedge clk_sys);
    msg_start <= 1'b0;
    data_valid <= 1'b0;
    {manchester_err, parity_err, cmd_sync_err} <= 3'h0;
    // released lines must not keep their last value
    cmd_word  <= ~cmd_word;
    data_word <= ~data_word;
    gap_err   <= err[3];
    @(posedge clk_sys);
    gap_err <= 1'b0;
    msg_end <= 1'b1;
    @(posedge clk_sys);
    msg_end <= 1'b0;
  endtask : send

endmodule : mcw_bc_model

// ==== testbench/mcw_record_writer_tb_top.sv ====
`timescale 1ns/100ps
module mcw_record_writer_tb_top;
  import mcw_pkg::*;

  logic        clk_sys, sys_rst, reg_wr, reg_rd, msg_start, force_busy_bit, illegal_bit;
  logic        bus_b, broadcast, data_valid, manchester_err, parity_err, cmd_sync_err;
  logic        gap_err, msg_end, respond_in_form, answered_busy, mem_wr, irq;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cmd_word, desc_ptr, time_tag, data_word;
  logic [15:0] mem_addr, mem_wdata;
  logic [15:0] cfg_v = 16'h0000;
  logic        in_msg = 1'b0;
  logic        ce;
  int          errors = 0;
  int          tests_run = 0;

  mcw_record_writer i_mcw_record_writer (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .msg_start(msg_start), .cmd_word(cmd_word), .desc_ptr(desc_ptr),
    .force_busy_bit(force_busy_bit), .illegal_bit(illegal_bit), .bus_b(bus_b),
    .broadcast(broadcast), .time_tag(time_tag), .data_valid(data_valid),
    .data_word(data_word), .manchester_err(manchester_err), .parity_err(parity_err),
    .cmd_sync_err(cmd_sync_err), .gap_err(gap_err), .msg_end(msg_end),
    .respond_in_form(respond_in_form), .answered_busy(answered_busy), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .irq(irq));

  mcw_bc_model i_mcw_bc_model (
    .clk_sys(clk_sys), .msg_start(msg_start), .cmd_word(cmd_word),
    .data_valid(data_valid), .data_word(data_word), .manchester_err(manchester_err),
    .parity_err(parity_err), .cmd_sync_err(cmd_sync_err), .gap_err(gap_err),
    .msg_end(msg_end));

  function automatic logic [15:0] b(input logic v);
    b = {15'h0000, v};
  endfunction : b

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : reg_read

  task automatic set_cfg(input logic [15:0] v);
    reg_write(REG_CFG, v);
    cfg_v = v;
  endtask : set_cfg

  task automatic run_msg(input logic [4:0] mc, input int nd, input logic [3:0] err,
                         input logic ill, input logic busy, input logic busb, input logic bc);
    logic [15:0] ptr, tag, dw, exp;
    logic        iwd, syn, wct, gap, undef;
    ptr   = {6'h05, mc, 5'h00};
    tag   = {3'h5, mc, 8'hC3};
    dw    = {8'h3C, 3'h0, mc};
    undef = (mc < 5'h10) || (mc == 5'h10) || (mc == 5'h12) || (mc == 5'h13);
    iwd   = (nd > 0) && (err[0] || err[1]);
    syn   = (nd > 0) && err[2];
    wct   = (mc >= 5'h10) ? (nd != 1) : (nd != 0);
    gap   = cfg_v[3] ? bc : err[3];
    exp   = {1'b0, iwd, gap, wct, syn, iwd | syn | wct | gap, busy | cfg_v[1], ill,
             2'b00, busb, mc};
    @(posedge clk_sys);
    desc_ptr       <= ptr;
    time_tag       <= tag;
    illegal_bit    <= ill;
    force_busy_bit <= busy;
    bus_b          <= busb;
    broadcast      <= bc;
    in_msg = 1'b1;
    i_mcw_bc_model.send(mc, nd, dw, err);
    in_msg = 1'b0;
    @(negedge clk_sys);
    check(b(respond_in_form), b(~ill & ~(undef & cfg_v[0])));
    check(b(answered_busy), b(busy | cfg_v[1]));
    check(b(mem_wr), 16'h0001);
    check(mem_addr, ptr);
    check(mem_wdata, exp);
    @(negedge clk_sys);
    check(b(mem_wr), 16'h0001);
    check(mem_addr, ptr + REC_TAG_OFS);
    check(mem_wdata, tag);
    @(negedge clk_sys);
    if (mc >= 5'h10 && nd > 0) begin
      check(b(mem_wr), 16'h0001);
      check(mem_addr, ptr + REC_DATA_OFS);
      check(mem_wdata, dw);
      @(negedge clk_sys);
    end
    check(b(mem_wr), 16'h0000);
  endtask : run_msg

  task automatic t_reset();
    logic [15:0] d;
    check(b(irq), 16'h0000);
    reg_read(REG_CFG, d);
    check(d, CFG_RST);
    reg_read(REG_IRQ_MASK, d);
    check(d, {13'h0000, IRQ_MASK_RST});
    reg_read(8'h14, d);
    check(d, 16'h0000);
  endtask : t_reset

  // a write while the clock enable is low must not land
  task automatic t_ce();
    logic [15:0] d;
    @(posedge clk_sys);
    ce <= 1'b0;
    reg_write(REG_CFG, 16'h0002);
    ce <= 1'b1;
    reg_read(REG_CFG, d);
    check(d, CFG_RST);
  endtask : t_ce

  task automatic t_layout();
    run_msg(5'h11, 1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h05, 0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    run_msg(5'h1F, 1, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
  endtask : t_layout

  task automatic t_inform();
    logic [4:0] codes [7] = '{5'h00, 5'h0F, 5'h10, 5'h12, 5'h13, 5'h11, 5'h1F};
    for (int u = 0; u < 2; u++) begin
      set_cfg({15'h0000, u[0]});
      foreach (codes[k]) begin
        run_msg(codes[k], (codes[k] >= 5'h10) ? 1 : 0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      end
    end
    set_cfg(16'h0000);
  endtask : t_inform

  task automatic t_errors();
    run_msg(5'h11, 1, 4'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h11, 1, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h11, 1, 4'h4, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h11, 1, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h11, 0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h11, 2, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h02, 1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_msg(5'h11, 1, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    set_cfg(16'h0008);
    run_msg(5'h11, 1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    set_cfg(16'h0002);
    run_msg(5'h04, 0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    set_cfg(16'h0000);
  endtask : t_errors

  task automatic t_irq();
    logic [15:0] d, cnt;
    reg_write(REG_IRQ_STAT, 16'h0007);
    reg_write(REG_IRQ_MASK, 16'h0001);
    repeat (2) @(negedge clk_sys);
    check(b(irq), 16'h0000);
    reg_read(REG_COUNT, cnt);
    run_msg(5'h08, 0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge clk_sys);
    check(b(irq), 16'h0001);
    reg_read(REG_IRQ_STAT, d);
    check(d, 16'h0001);
    reg_read(REG_LAST_STAT, d);
    check(d, 16'h0008);
    reg_read(REG_COUNT, d);
    check(d, cnt + 16'h0001);
    reg_write(REG_IRQ_STAT, 16'h0001);
    repeat (2) @(negedge clk_sys);
    check(b(irq), 16'h0000);
    reg_write(REG_IRQ_MASK, 16'h0002);
    run_msg(5'h08, 0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge clk_sys);
    check(b(irq), 16'h0000);
    run_msg(5'h11, 0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge clk_sys);
    check(b(irq), 16'h0001);
  endtask : t_irq

  // no record word may be written while the message is still open
  always @(negedge clk_sys) begin
    if (in_msg) begin
      check(b(mem_wr), 16'h0000);
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    #40000;
    errors++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, force_busy_bit, illegal_bit, bus_b, broadcast} = 6'h00;
    ce = 1'b1;
    reg_addr = 8'h00;
    {reg_wdata, desc_ptr, time_tag} = 48'h0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_ce();
    t_layout();
    t_inform();
    t_errors();
    t_irq();
    finish_test();
  end

endmodule : mcw_record_writer_tb_top
